// ==== src/csoc_core_ctrl.sv ====
// processor state, privilege, operand ordering and trap control
// assumes the sequencer and bus controller sit on mclk; only the break pin is asynchronous
`timescale 1ns/10ps

// What this block does
// - long-word bytes ordered little-endian, least significant byte at lowest address
// - word and long operands and instructions must sit on word boundaries
// - sixteen megabyte linear range in each of eight selectable spaces
// - page fault suspends access, then state is restored and instruction restarted
// - always exactly one of normal, exception, halted or background states
// - interrupts, traps, trace, errors, bus errors and reset enter exception state
// - second bus error during bus error handling halts the processor, or enters background state when background is enabled
// - background enabled only if break pin low at reset; then entered on events
// - background state opens the serial debug interface
// - supervisor bit picks privilege level and user or supervisor stack pointer
// - supervisor may run everything; user refused privileged subset like status AND
// - unimplemented opcodes and illegal addressing modes take a trap
// - bit-field, module, swap, coprocessor, pack and memory-indirect are unimplemented
// - seven basic addressing modes decoded including pc relative and index
// - low-power stop and table interpolate groups are accepted
// - add with extend sums source, destination and extend flag, all sizes
// - immediate adds add immediate (source when a zero imm16 add immediate) to destination and write back, all sizes
// - status word holds mask, trace bits, supervisor bit and five flags
// - flag-only operations read upper byte as zero and ignore it on write
module csoc_core_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic breakpoint_request_pin_n,
  input wire csoc_pkg::csoc_instr_t instr,
  input wire csoc_pkg::csoc_access_t access,
  input wire csoc_pkg::csoc_bus_evt_t bus_evt,
  input wire logic handler_done,
  input wire logic debug_resume,
  input wire logic [31:0] access_data,
  output logic [1:0] proc_state,
  output logic [15:0] processor_status_word,
  output logic supervisor_level,
  output logic use_supervisor_stack,
  output logic [31:0] result_data,
  output logic result_valid,
  output logic [15:0] flags_read_data,
  output logic exception_taken,
  output logic illegal_trap,
  output logic privilege_trap,
  output logic misaligned,
  output logic access_suspended,
  output logic restart_instr,
  output logic [csoc_pkg::ADDR_W-1:0] linear_addr,
  output logic [csoc_pkg::FC_W-1:0] addr_space,
  output logic [31:0] byte_lanes,
  output logic debug_port_enable,
  output logic background_enabled,
  output logic low_power_req,
  output logic table_op_req
);

  // width mask for a size
  function automatic logic [31:0] size_mask(input csoc_pkg::csoc_size_t sz);
    case (sz)
      csoc_pkg::CSOC_SZ_BYTE: size_mask = 32'h0000_00ff;
      csoc_pkg::CSOC_SZ_WORD: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction

  // sign bit of a sized value
  function automatic logic size_msb(input logic [31:0] v, input csoc_pkg::csoc_size_t sz);
    case (sz)
      csoc_pkg::CSOC_SZ_BYTE: size_msb = v[7];
      csoc_pkg::CSOC_SZ_WORD: size_msb = v[15];
      default: size_msb = v[31];
    endcase
  endfunction

  logic brk_meta_reg;
  logic brk_sync_reg;
  logic in_reset_reg;
  logic bgnd_en_reg;
  csoc_pkg::csoc_state_t state_reg;
  csoc_pkg::csoc_state_t state_next;
  logic [15:0] psw_reg;
  logic [15:0] psw_next;
  logic in_buserr_reg;
  logic suspended_reg;
  logic restart_reg;
  logic exc_reg;
  logic ill_reg;
  logic priv_reg;
  logic [31:0] result_reg;
  logic res_valid_reg;
  logic [15:0] flags_rd_reg;
  logic mis_reg;
  logic [31:0] lanes_reg;
  logic lp_reg;
  logic tbl_reg;

  // decode
  wire normal_run = (state_reg == csoc_pkg::CSOC_NORMAL);
  wire is_super = psw_reg[csoc_pkg::PSW_SUPER];
  wire op_valid = instr.valid && normal_run && !suspended_reg;
  wire op_privileged = (instr.op == csoc_pkg::CSOC_OP_AND_STATUS) ||
                       (instr.op == csoc_pkg::CSOC_OP_LOW_POWER) ||
                       (instr.op == csoc_pkg::CSOC_OP_PRIV_OTHER);
  wire priv_violation = op_valid && op_privileged && !is_super;
  // mode 7 only has the five extension forms; others include memory indirect
  wire ext_ok = (instr.ea_reg == csoc_pkg::EXT_ABS_W) || (instr.ea_reg == csoc_pkg::EXT_ABS_L) ||
                (instr.ea_reg == csoc_pkg::EXT_PC_DISP) ||
                (instr.ea_reg == csoc_pkg::EXT_PC_INDEX) ||
                (instr.ea_reg == csoc_pkg::EXT_IMM);
  wire index_full = ((instr.ea_mode == csoc_pkg::EA_INDEX) ||
                     (instr.ea_mode == csoc_pkg::EA_EXT &&
                      instr.ea_reg == csoc_pkg::EXT_PC_INDEX)) &&
                    instr.ext_word[csoc_pkg::IDX_FULL_BIT];
  wire ea_illegal = ((instr.ea_mode == csoc_pkg::EA_EXT) && !ext_ok) || index_full;
  wire addr_reg_byte = (instr.ea_mode == csoc_pkg::EA_AREG) &&
                       (instr.size == csoc_pkg::CSOC_SZ_BYTE);
  wire unimpl = op_valid && !priv_violation &&
                ((instr.op == csoc_pkg::CSOC_OP_UNIMPL) || ea_illegal || addr_reg_byte);
  wire is_add = (instr.op == csoc_pkg::CSOC_OP_ADD_EXTEND) ||
                (instr.op == csoc_pkg::CSOC_OP_ADD_IMM) ||
                (instr.op == csoc_pkg::CSOC_OP_ADD_QUICK);
  wire do_add = op_valid && !priv_violation && !unimpl && is_add;

  // adder: extend flag only joins the add-with-extend form
  wire [31:0] msk = size_mask(instr.size);
  wire [31:0] src_v = (instr.op == csoc_pkg::CSOC_OP_ADD_EXTEND) ? (instr.src & msk)
                                                                   : (instr.imm16 == 16'h0000 &&
                      instr.op == csoc_pkg::CSOC_OP_ADD_IMM) ? (instr.src & msk)
                                                                   : ({16'h0000, instr.imm16} & msk);
  wire [31:0] dst_v = instr.dst & msk;
  wire xin = (instr.op == csoc_pkg::CSOC_OP_ADD_EXTEND) && psw_reg[csoc_pkg::PSW_X];
  wire [32:0] raw_sum = {1'b0, src_v} + {1'b0, dst_v} + {32'h0000_0000, xin};
  wire [31:0] sum = raw_sum[31:0] & msk;
  wire carry = (instr.size == csoc_pkg::CSOC_SZ_BYTE) ? raw_sum[8] :
               (instr.size == csoc_pkg::CSOC_SZ_WORD) ? raw_sum[16] : raw_sum[32];
  wire s_n = size_msb(sum, instr.size);
  wire s_ov = (size_msb(src_v, instr.size) == size_msb(dst_v, instr.size)) &&
              (s_n != size_msb(dst_v, instr.size));
  // extend form keeps zero clear-only so multi-precision chains test the whole value
  wire s_z = (instr.op == csoc_pkg::CSOC_OP_ADD_EXTEND) ?
             (psw_reg[csoc_pkg::PSW_Z] && sum == 32'h0000_0000) : (sum == 32'h0000_0000);
  wire [31:0] add_result = (instr.dst & ~msk) | sum;

  // operand address handling
  wire mis_now = access.valid && access.addr[0] &&
                 (access.is_fetch || access.size != csoc_pkg::CSOC_SZ_BYTE);
  wire [31:0] be_lanes = {access_data[7:0], access_data[15:8],
                          access_data[23:16], access_data[31:24]};

  // event priority
  wire double_fault = bus_evt.bus_error && in_buserr_reg;
  wire to_background = bgnd_en_reg && normal_run &&
                       (bus_evt.breakpoint ||
                        (op_valid && !priv_violation && instr.op == csoc_pkg::CSOC_OP_BACKGROUND));
  wire exc_event = normal_run && (bus_evt.interrupt || bus_evt.bus_error || bus_evt.trace ||
                   priv_violation || unimpl || mis_now ||
                   (op_valid && instr.op == csoc_pkg::CSOC_OP_TRAP) ||
                   (op_valid && !bgnd_en_reg && instr.op == csoc_pkg::CSOC_OP_BACKGROUND) ||
                   (!bgnd_en_reg && bus_evt.breakpoint));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      csoc_pkg::CSOC_NORMAL: begin
        if (to_background) begin
          state_next = csoc_pkg::CSOC_BACKGROUND;
        end else if (exc_event) begin
          state_next = csoc_pkg::CSOC_EXCEPTION;
        end
      end
      csoc_pkg::CSOC_EXCEPTION: begin
        if (double_fault) begin
          state_next = bgnd_en_reg ? csoc_pkg::CSOC_BACKGROUND : csoc_pkg::CSOC_HALTED;
        end else if (handler_done) begin
          state_next = csoc_pkg::CSOC_NORMAL;
        end
      end
      csoc_pkg::CSOC_HALTED: state_next = csoc_pkg::CSOC_HALTED;
      csoc_pkg::CSOC_BACKGROUND: begin
        if (debug_resume) begin
          state_next = csoc_pkg::CSOC_NORMAL;
        end
      end
      default: state_next = csoc_pkg::CSOC_HALTED;
    endcase
  end

  // status word update; a refused instruction leaves it alone
  always_comb begin
    psw_next = psw_reg;
    if (state_reg == csoc_pkg::CSOC_NORMAL && state_next == csoc_pkg::CSOC_EXCEPTION &&
        !priv_violation) begin
      psw_next[csoc_pkg::PSW_SUPER] = 1'b1;
      psw_next[csoc_pkg::PSW_TRACE_HI:csoc_pkg::PSW_TRACE_LO] = 2'b00;
    end else if (op_valid && !priv_violation && !unimpl) begin
      case (instr.op)
        csoc_pkg::CSOC_OP_AND_STATUS:
          psw_next = psw_reg & instr.imm16 & csoc_pkg::PSW_DEFINED;
        csoc_pkg::CSOC_OP_FLAGS_WRITE:
          psw_next = (psw_reg & ~csoc_pkg::FLAGS_DEFINED) |
                     (instr.imm16 & csoc_pkg::FLAGS_DEFINED);
        csoc_pkg::CSOC_OP_ADD_EXTEND, csoc_pkg::CSOC_OP_ADD_IMM: begin
          psw_next[csoc_pkg::PSW_X] = carry;
          psw_next[csoc_pkg::PSW_N] = s_n;
          psw_next[csoc_pkg::PSW_Z] = s_z;
          psw_next[csoc_pkg::PSW_V] = s_ov;
          psw_next[csoc_pkg::PSW_C] = carry;
        end
        csoc_pkg::CSOC_OP_ADD_QUICK: begin
          if (instr.ea_mode != csoc_pkg::EA_AREG) begin
            psw_next[csoc_pkg::PSW_X] = carry;
            psw_next[csoc_pkg::PSW_N] = s_n;
            psw_next[csoc_pkg::PSW_Z] = s_z;
            psw_next[csoc_pkg::PSW_V] = s_ov;
            psw_next[csoc_pkg::PSW_C] = carry;
          end
        end
        default: psw_next = psw_reg;
      endcase
    end
  end

  // pin strap: second stage only is read
  always_ff @(posedge mclk) begin
    brk_meta_reg <= breakpoint_request_pin_n;
    brk_sync_reg <= brk_meta_reg;
  end

  always_ff @(posedge mclk) begin
    in_reset_reg <= reset;
    if (reset) begin
      bgnd_en_reg <= 1'b0;
    end else if (in_reset_reg) begin
      bgnd_en_reg <= !brk_sync_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= csoc_pkg::CSOC_EXCEPTION;
      psw_reg <= csoc_pkg::PSW_RESET;
      in_buserr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      psw_reg <= psw_next;
      if (state_next != csoc_pkg::CSOC_EXCEPTION) begin
        in_buserr_reg <= 1'b0;
      end else if (normal_run && bus_evt.bus_error) begin
        in_buserr_reg <= 1'b1;
      end
    end
  end

  // page fault suspension and restart
  always_ff @(posedge mclk) begin
    if (reset) begin
      suspended_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= suspended_reg && bus_evt.fault_fixed;
      if (bus_evt.page_fault && normal_run) begin
        suspended_reg <= 1'b1;
      end else if (bus_evt.fault_fixed) begin
        suspended_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      exc_reg <= 1'b0;
      ill_reg <= 1'b0;
      priv_reg <= 1'b0;
      result_reg <= 32'h0000_0000;
      res_valid_reg <= 1'b0;
      flags_rd_reg <= 16'h0000;
      mis_reg <= 1'b0;
      lanes_reg <= 32'h0000_0000;
      lp_reg <= 1'b0;
      tbl_reg <= 1'b0;
    end else begin
      exc_reg <= normal_run && state_next == csoc_pkg::CSOC_EXCEPTION;
      ill_reg <= unimpl;
      priv_reg <= priv_violation;
      res_valid_reg <= do_add;
      if (do_add) begin
        result_reg <= add_result;
      end
      if (op_valid && instr.op == csoc_pkg::CSOC_OP_FLAGS_READ) begin
        flags_rd_reg <= psw_reg & csoc_pkg::FLAGS_DEFINED;
      end
      mis_reg <= mis_now;
      if (access.valid && !mis_now) begin
        lanes_reg <= be_lanes;
      end
      lp_reg <= op_valid && !priv_violation && instr.op == csoc_pkg::CSOC_OP_LOW_POWER;
      tbl_reg <= op_valid && !unimpl && instr.op == csoc_pkg::CSOC_OP_TABLE;
    end
  end

  assign proc_state = state_reg;
  assign processor_status_word = psw_reg;
  assign supervisor_level = is_super;
  assign use_supervisor_stack = is_super;
  assign result_data = result_reg;
  assign result_valid = res_valid_reg;
  assign flags_read_data = flags_rd_reg;
  assign exception_taken = exc_reg;
  assign illegal_trap = ill_reg;
  assign privilege_trap = priv_reg;
  assign misaligned = mis_reg;
  assign access_suspended = suspended_reg;
  assign restart_instr = restart_reg;
  assign linear_addr = access.addr[csoc_pkg::ADDR_W-1:0];
  assign addr_space = access.space;
  assign byte_lanes = lanes_reg;
  assign debug_port_enable = (state_reg == csoc_pkg::CSOC_BACKGROUND);
  assign background_enabled = bgnd_en_reg;
  assign low_power_req = lp_reg;
  assign table_op_req = tbl_reg;

  property p_priv_keeps_psw;
    @(posedge mclk) disable iff (reset) priv_violation |=> privilege_trap && $stable(psw_reg);
  endproperty
  a_priv_keeps_psw: assert property (p_priv_keeps_psw) else $error("privilege refusal changed status");

  property p_double_halt;
    @(posedge mclk) disable iff (reset)
      (state_reg == csoc_pkg::CSOC_EXCEPTION && double_fault && !bgnd_en_reg) |=>
      (proc_state == csoc_pkg::CSOC_HALTED) [*3];
  endproperty
  a_double_halt: assert property (p_double_halt) else $error("double bus error did not halt");

  property p_stack_follows_super;
    @(posedge mclk) disable iff (reset) use_supervisor_stack == psw_reg[csoc_pkg::PSW_SUPER];
  endproperty
  a_stack_follows_super: assert property (p_stack_follows_super) else $error("stack select wrong");

  property p_unimpl_trap;
    @(posedge mclk) disable iff (reset)
      (op_valid && instr.op == csoc_pkg::CSOC_OP_UNIMPL && is_super) |=> illegal_trap &&
      proc_state == csoc_pkg::CSOC_EXCEPTION;
  endproperty
  a_unimpl_trap: assert property (p_unimpl_trap) else $error("unimplemented opcode not trapped");

  sequence s_fault;
    normal_run && bus_evt.page_fault;
  endsequence
  property p_restart;
    @(posedge mclk) disable iff (reset)
      s_fault ##1 (access_suspended && bus_evt.fault_fixed) |=> restart_instr && !access_suspended;
  endproperty
  a_restart: assert property (p_restart) else $error("fault fix did not restart");

  property p_flags_upper_zero;
    @(posedge mclk) disable iff (reset) flags_read_data[15:8] == 8'h00;
  endproperty
  a_flags_upper_zero: assert property (p_flags_upper_zero) else $error("flags upper byte not zero");

  property p_misalign;
    @(posedge mclk) disable iff (reset)
      (normal_run && access.valid && access.addr[0] && access.size == csoc_pkg::CSOC_SZ_LONG) |=>
      misaligned && proc_state == csoc_pkg::CSOC_EXCEPTION;
  endproperty
  a_misalign: assert property (p_misalign) else $error("odd long access accepted");

  property p_debug_port;
    @(posedge mclk) disable iff (reset)
      debug_port_enable |-> background_enabled && proc_state == csoc_pkg::CSOC_BACKGROUND;
  endproperty
  a_debug_port: assert property (p_debug_port) else $error("debug port open without background");

  property p_add_result;
    @(posedge mclk) disable iff (reset) do_add |=> result_valid && result_data == $past(add_result);
  endproperty
  a_add_result: assert property (p_add_result) else $error("add result not delivered");

endmodule // csoc_core_ctrl

// ==== src/csoc_pkg.sv ====
// shared constants and carriers for the processor state and operand control block
// assumes one 100 MHz clock and a synchronous active high reset
package csoc_pkg;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned FC_W = 3;
  localparam logic [15:0] PSW_RESET = 16'h2700;
  localparam int unsigned PSW_TRACE_HI = 15;
  localparam int unsigned PSW_TRACE_LO = 14;
  localparam int unsigned PSW_SUPER = 13;
  localparam int unsigned PSW_MASK_HI = 10;
  localparam int unsigned PSW_MASK_LO = 8;
  localparam int unsigned PSW_X = 4;
  localparam int unsigned PSW_N = 3;
  localparam int unsigned PSW_Z = 2;
  localparam int unsigned PSW_V = 1;
  localparam int unsigned PSW_C = 0;
  localparam logic [15:0] PSW_DEFINED = 16'hc71f;
  localparam logic [15:0] FLAGS_DEFINED = 16'h001f;

  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_IND = 3'h2;
  localparam logic [2:0] EA_POSTINC = 3'h3;
  localparam logic [2:0] EA_PREDEC = 3'h4;
  localparam logic [2:0] EA_DISP = 3'h5;
  localparam logic [2:0] EA_INDEX = 3'h6;
  localparam logic [2:0] EA_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_W = 3'h0;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] EXT_PC_DISP = 3'h2;
  localparam logic [2:0] EXT_PC_INDEX = 3'h3;
  localparam logic [2:0] EXT_IMM = 3'h4;
  localparam int unsigned IDX_FULL_BIT = 8;

  typedef enum logic [1:0] {
    CSOC_SZ_BYTE = 2'b00,
    CSOC_SZ_WORD = 2'b01,
    CSOC_SZ_LONG = 2'b10
  } csoc_size_t;

  typedef enum logic [1:0] {
    CSOC_NORMAL = 2'b00,
    CSOC_EXCEPTION = 2'b01,
    CSOC_HALTED = 2'b10,
    CSOC_BACKGROUND = 2'b11
  } csoc_state_t;

  typedef enum logic [3:0] {
    CSOC_OP_NONE = 4'h0,
    CSOC_OP_ADD_EXTEND = 4'h1,
    CSOC_OP_ADD_IMM = 4'h2,
    CSOC_OP_ADD_QUICK = 4'h3,
    CSOC_OP_AND_STATUS = 4'h4,
    CSOC_OP_FLAGS_WRITE = 4'h5,
    CSOC_OP_FLAGS_READ = 4'h6,
    CSOC_OP_BACKGROUND = 4'h7,
    CSOC_OP_TRAP = 4'h8,
    CSOC_OP_LOW_POWER = 4'h9,
    CSOC_OP_TABLE = 4'ha,
    CSOC_OP_UNIMPL = 4'hb,
    CSOC_OP_PRIV_OTHER = 4'hc
  } csoc_op_t;

  // one decoded instruction handed over by the sequencer
  typedef struct packed {
    logic valid;
    csoc_op_t op;
    csoc_size_t size;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic [15:0] ext_word;
    logic predec_mem;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] imm16;
  } csoc_instr_t;

  // one memory operand request from the bus side
  typedef struct packed {
    logic valid;
    logic [FC_W-1:0] space;
    logic [31:0] addr;
    csoc_size_t size;
    logic is_fetch;
  } csoc_access_t;

  // bus controller status for the current cycle
  typedef struct packed {
    logic page_fault;
    logic fault_fixed;
    logic bus_error;
    logic interrupt;
    logic breakpoint;
    logic trace;
  } csoc_bus_evt_t;

  localparam int unsigned LANE_W = 8;

endpackage : csoc_pkg

// ==== tb/csoc_bus_model.sv ====
// bus side partner: byte memory, event lines and the break strap pin
// assumes the testbench changes its requests at the falling edge of mclk
`timescale 1ns/10ps
module csoc_bus_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic strap_low,
  input wire csoc_pkg::csoc_access_t access,
  input wire csoc_pkg::csoc_bus_evt_t evt_req,
  output logic breakpoint_request_pin_n,
  output csoc_pkg::csoc_bus_evt_t bus_evt,
  output logic [31:0] access_data
);
  logic [7:0] mem [16];
  logic [31:0] last_reg = 32'h0;
  logic [3:0] base;
  logic [31:0] word;
  assign base = {access.addr[3:1], 1'b0};
  assign word = {mem[base], mem[base + 4'h1], mem[base + 4'h2], mem[base + 4'h3]};
  // an idle bus shows the inverse of the last word, so stale data never looks valid
  assign access_data = access.valid ? word : ~last_reg;
  assign bus_evt = evt_req;
  // strap held for the whole reset so the synchroniser has settled at release
  assign breakpoint_request_pin_n = ~(strap_low & reset);
  initial for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
  always @(posedge mclk) if (access.valid) last_reg <= word;
endmodule // csoc_bus_model

// ==== tb/testbench.sv ====
// self-checking bench for the processor state and operand control block
// assumes inputs change at the falling edge and outputs settle before the next one
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic strap_low = 1'b0;
  csoc_pkg::csoc_instr_t instr = '0;
  csoc_pkg::csoc_access_t access = '0;
  csoc_pkg::csoc_bus_evt_t evt_req = '0;
  csoc_pkg::csoc_bus_evt_t bus_evt;
  logic handler_done = 1'b0;
  logic debug_resume = 1'b0;
  logic breakpoint_request_pin_n;
  logic [31:0] access_data, result_data, byte_lanes;
  logic [1:0] proc_state;
  logic [15:0] processor_status_word, flags_read_data;
  logic supervisor_level, use_supervisor_stack, result_valid, exception_taken, illegal_trap;
  logic privilege_trap, misaligned, access_suspended, restart_instr, debug_port_enable;
  logic background_enabled, low_power_req, table_op_req;
  logic [csoc_pkg::ADDR_W-1:0] linear_addr;
  logic [csoc_pkg::FC_W-1:0] addr_space;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  csoc_bus_model i_model (.mclk(mclk), .reset(reset), .strap_low(strap_low), .access(access),
    .evt_req(evt_req), .breakpoint_request_pin_n(breakpoint_request_pin_n), .bus_evt(bus_evt),
    .access_data(access_data));

  csoc_core_ctrl i_dut (.mclk(mclk), .reset(reset),
    .breakpoint_request_pin_n(breakpoint_request_pin_n), .instr(instr), .access(access),
    .bus_evt(bus_evt), .handler_done(handler_done), .debug_resume(debug_resume),
    .access_data(access_data), .proc_state(proc_state),
    .processor_status_word(processor_status_word), .supervisor_level(supervisor_level),
    .use_supervisor_stack(use_supervisor_stack), .result_data(result_data),
    .result_valid(result_valid), .flags_read_data(flags_read_data),
    .exception_taken(exception_taken), .illegal_trap(illegal_trap),
    .privilege_trap(privilege_trap), .misaligned(misaligned),
    .access_suspended(access_suspended), .restart_instr(restart_instr),
    .linear_addr(linear_addr), .addr_space(addr_space), .byte_lanes(byte_lanes),
    .debug_port_enable(debug_port_enable), .background_enabled(background_enabled),
    .low_power_req(low_power_req), .table_op_req(table_op_req));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // generous ceiling: the sequence needs well under 200 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic low);
    strap_low = low;
    reset = 1'b1;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
  endtask

  task automatic run(input csoc_pkg::csoc_op_t op, input csoc_pkg::csoc_size_t sz,
                     input logic [31:0] src, input logic [31:0] dst, input logic [15:0] imm);
    instr.op = op;
    instr.size = sz;
    instr.src = src;
    instr.dst = dst;
    instr.imm16 = imm;
    instr.valid = 1'b1;
    @(negedge mclk);
    instr.valid = 1'b0;
  endtask

  // event order: page_fault, fault_fixed, bus_error, interrupt, breakpoint, trace
  task automatic evt(input logic [5:0] v);
    evt_req = v;
    @(negedge mclk);
    evt_req = '0;
  endtask

  task automatic acc(input logic [2:0] sp, input logic [31:0] addr, input csoc_pkg::csoc_size_t sz);
    access = '{valid: 1'b1, space: sp, addr: addr, size: sz, is_fetch: 1'b0};
    @(negedge mclk);
    access.valid = 1'b0;
  endtask

  task automatic done;
    handler_done = 1'b1;
    @(negedge mclk);
    handler_done = 1'b0;
  endtask

  initial begin
    do_reset(1'b0);
    chk("state", csoc_pkg::CSOC_EXCEPTION, proc_state);
    chk("psw", 16'h2700, processor_status_word);
    chk("super", 1'b1, use_supervisor_stack);
    chk("bg_en", 1'b0, background_enabled);
    done();
    chk("state", csoc_pkg::CSOC_NORMAL, proc_state);
    run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h1234fffe, 16'h0003);
    chk("add_immediate_op_w", 32'h12340001, result_data);
    chk("flags", 5'h11, processor_status_word[4:0]);
    run(csoc_pkg::CSOC_OP_ADD_EXTEND, csoc_pkg::CSOC_SZ_BYTE, 32'h10, 32'haabbcc20, 16'h0);
    chk("add_with_extend_op_b", 32'haabbcc31, result_data);
    run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_BYTE, 32'h0, 32'haabbccf0, 16'h0011);
    chk("add_immediate_op_b", 32'haabbcc01, result_data);
    run(csoc_pkg::CSOC_OP_ADD_EXTEND, csoc_pkg::CSOC_SZ_LONG, 32'h0, 32'hffffffff, 16'h0);
    chk("add_with_extend_op_l", 32'h0, result_data);
    chk("rvalid", 1'b1, result_valid);
    run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_LONG, 32'h0, 32'h7fffffff, 16'h0001);
    chk("add_immediate_op_l", 32'h80000000, result_data);
    run(csoc_pkg::CSOC_OP_FLAGS_READ, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0);
    chk("flags_rd", 16'h000a, flags_read_data);
    run(csoc_pkg::CSOC_OP_FLAGS_WRITE, csoc_pkg::CSOC_SZ_WORD, 32'hff00, 32'h0, 16'hff00);
    chk("psw_hi", 8'h27, processor_status_word[15:8]);
    run(csoc_pkg::CSOC_OP_LOW_POWER, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0);
    chk("low_power_halt_instr", 1'b1, low_power_req);
    run(csoc_pkg::CSOC_OP_TABLE, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0);
    chk("table", 1'b1, table_op_req);
    run(csoc_pkg::CSOC_OP_AND_STATUS, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'hdfff);
    chk("user", 2'b00, {supervisor_level, use_supervisor_stack});
    run(csoc_pkg::CSOC_OP_AND_STATUS, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0000);
    chk("priv", 2'b11, {privilege_trap, exception_taken});
    chk("psw_keep", 8'h07, processor_status_word[15:8]);
    done();
    run(csoc_pkg::CSOC_OP_UNIMPL, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0);
    chk("unimpl", 1'b1, illegal_trap);
    done();
    for (int m = 0; m < 12; m++) begin
      instr.ea_mode = (m < 7) ? 3'(m) : 3'h7;
      instr.ea_reg = (m < 7) ? 3'h0 : 3'(m - 7);
      run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0001);
      chk("ea_ok", 1'b0, illegal_trap);
    end
    instr.ea_reg = 3'h5;
    run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0001);
    chk("ea_bad", 1'b1, illegal_trap);
    done();
    instr.ea_mode = csoc_pkg::EA_INDEX;
    instr.ext_word = 16'h0100;
    run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0001);
    chk("mem_ind", 1'b1, illegal_trap);
    done();
    instr = '0;
    access = '{valid: 1'b1, space: 3'h5, addr: 32'h12345674, size: csoc_pkg::CSOC_SZ_LONG,
               is_fetch: 1'b0};
    #1 chk("lin", 27'h5345674, {addr_space, linear_addr});
    acc(3'h5, 32'h12345674, csoc_pkg::CSOC_SZ_LONG);
    chk("lanes", 32'h17161514, byte_lanes);
    chk("align", 1'b0, misaligned);
    acc(3'h1, 32'h00000005, csoc_pkg::CSOC_SZ_WORD);
    chk("misalign", 1'b1, misaligned);
    done();
    evt(6'h20);
    chk("susp", 1'b1, access_suspended);
    run(csoc_pkg::CSOC_OP_ADD_IMM, csoc_pkg::CSOC_SZ_WORD, 32'h0, 32'h0, 16'h0001);
    chk("held", 1'b0, result_valid);
    evt(6'h10);
    chk("restart", 2'b10, {restart_instr, access_suspended});
    for (int e = 0; e < 2; e++) begin
      evt(e == 0 ? 6'h04 : 6'h01);
      chk("exc", 3'b101, {exception_taken, proc_state});
      done();
    end
    evt(6'h08);
    chk("buserr", csoc_pkg::CSOC_EXCEPTION, proc_state);
    evt(6'h08);
    chk("halt", csoc_pkg::CSOC_HALTED, proc_state);
    do_reset(1'b1);
    chk("bg_en", 1'b1, background_enabled);
    done();
    evt(6'h02);
    chk("bgnd", 3'b111, {debug_port_enable, proc_state});
    debug_resume = 1'b1;
    @(negedge mclk);
    debug_resume = 1'b0;
    chk("resume", csoc_pkg::CSOC_NORMAL, proc_state);
    evt(6'h08);
    evt(6'h08);
    chk("dbl", csoc_pkg::CSOC_BACKGROUND, proc_state);
    conclude();
  end
endmodule // testbench
